// ===== sdi_pkg.sv
package sdi_pkg;

  // ==========================================================================
  // Register map (printed offsets are indices, byte address is index times 4)
  // ==========================================================================
  localparam logic [7:0] SDI_IDX_DRIVE_CHAN2 = 8'h20;
  localparam logic [7:0] SDI_IDX_DRIVE_CHAN3 = 8'h21;
  localparam logic [7:0] SDI_IDX_MAKER = 8'h7E;
  localparam logic [7:0] SDI_IDX_PART = 8'h7F;
  localparam logic [7:0] SDI_IDX_CTRL = 8'h40;

  // ==========================================================================
  // Field layout of a drive register
  // ==========================================================================
  localparam int SDI_LEVEL_LSB = 11;
  localparam int SDI_CAL_LSB = 6;
  localparam int SDI_FIELD_W = 5;
  localparam logic [4:0] SDI_LEVEL_RST = 5'h00;
  localparam logic [4:0] SDI_CAL_RST = 5'h00;

  // Control register bit positions
  localparam int SDI_CTRL_OVR_BIT = 0;
  localparam int SDI_CTRL_AAD_BIT = 1;

  // ==========================================================================
  // Identity values (arbitrary, neutral)
  // ==========================================================================
  localparam logic [15:0] SDI_MAKER_CODE = 16'hA5A5;
  localparam logic [15:0] SDI_PART_CODE = 16'h0001;

  localparam int SDI_NCHAN = 2;

  // Wishbone request carrier
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [9:0] adr;
    logic [31:0] dat;
  } sdi_wb_req_t;

  // Calibration result carrier, one per channel
  typedef struct packed {
    logic valid;
    logic initial_phase;
    logic [4:0] drive;
  } sdi_cal_t;

endpackage

// ===== sdi_drive_chan.sv
`timescale 1ns/1ns
// ============================================================================
// One channel: writable drive level and calibrated drive capture
// ============================================================================
module sdi_drive_chan (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_wr,
  input wire logic [4:0] i_wr_level,
  input wire sdi_pkg::sdi_cal_t i_cal,
  input wire logic i_auto_amplitude_disable,
  output logic [4:0] o_level,
  output logic [4:0] o_cal
);

  logic [4:0] next_level;
  logic [4:0] next_cal;

  // Next values for level and calibrated drive
  always_comb begin
    next_level = o_level;
    next_cal = o_cal;
    if (i_wr) begin
      next_level = i_wr_level;
    end
    // Initial calibration always captures; corrections only when not disabled
    if (i_cal.valid && (i_cal.initial_phase || !i_auto_amplitude_disable)) begin
      next_cal = i_cal.drive;
    end
  end

  // Registers
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_level <= sdi_pkg::SDI_LEVEL_RST;
      o_cal <= sdi_pkg::SDI_CAL_RST;
    end else begin
      o_level <= next_level;
      o_cal <= next_cal;
    end
  end

endmodule

// ===== sdi_regs.sv
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ns
module sdi_regs (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire sdi_pkg::sdi_wb_req_t i_wb,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire sdi_pkg::sdi_cal_t [1:0] i_cal,
  output logic [4:0] o_chan2_drive_level,
  output logic [4:0] o_chan3_drive_level,
  output logic o_drive_override_enable,
  output logic o_auto_amplitude_disable
);

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  // Word index of the request
  logic [7:0] idx;
  // Request taken at this edge, split by direction
  logic req;
  logic wr;
  logic rd;
  // Register hits that carry writable state
  logic hit_drive2;
  logic hit_drive3;
  logic hit_ctrl;
  // Byte lanes that carry the fields
  logic lanes_hi;
  logic lane_lo;
  // Write strobes, one per writable register
  logic wr_drive2;
  logic wr_drive3;
  logic wr_ctrl;
  logic [1:0] chan_wr;
  // Field values carried by a write
  logic [4:0] wr_level;
  logic wr_ovr;
  logic wr_aad;
  // Channel state, index 0 is channel 2 and index 1 is channel 3
  logic [4:0] lvl [2];
  logic [4:0] cal [2];
  // Read words
  logic [15:0] word_drive2;
  logic [15:0] word_drive3;
  logic [15:0] word_ctrl;
  logic [15:0] word_sel;
  // Next values of the registered outputs
  logic [31:0] next_dat;
  logic next_ack;
  logic next_ovr;
  logic next_aad;
  logic [4:0] next_chan2;
  logic [4:0] next_chan3;

  // Index from the byte address; a pending ack blocks a second take
  assign idx = i_wb.adr[9:2];
  assign req = i_wb.cyc && i_wb.stb && !o_wb_ack;
  assign wr = req && i_wb.we;
  assign rd = req && !i_wb.we;

  // One hit per writable index; identity indices need none
  assign hit_drive2 = idx == sdi_pkg::SDI_IDX_DRIVE_CHAN2;
  assign hit_drive3 = idx == sdi_pkg::SDI_IDX_DRIVE_CHAN3;
  assign hit_ctrl = idx == sdi_pkg::SDI_IDX_CTRL;

  // Level bits sit in byte lane 1, control bits in byte lane 0
  assign lanes_hi = i_wb.sel[1];
  assign lane_lo = i_wb.sel[0];

  // Write strobes; writes to identity or unmapped indices are lost
  assign wr_drive2 = wr && lanes_hi && hit_drive2;
  assign wr_drive3 = wr && lanes_hi && hit_drive3;
  assign wr_ctrl = wr && lane_lo && hit_ctrl;

  // Strobe vector for the channel loop
  assign chan_wr = {wr_drive3, wr_drive2};

  // Only the level bits are taken; calibrated and reserved bits are dropped
  assign wr_level = i_wb.dat[sdi_pkg::SDI_LEVEL_LSB +: sdi_pkg::SDI_FIELD_W];
  assign wr_ovr = i_wb.dat[sdi_pkg::SDI_CTRL_OVR_BIT];
  assign wr_aad = i_wb.dat[sdi_pkg::SDI_CTRL_AAD_BIT];

  // ==========================================================================
  // Drive channels
  // ==========================================================================
  // One level and calibrated drive pair per channel
  genvar g;
  generate
    for (g = 0; g < sdi_pkg::SDI_NCHAN; g++) begin : gen_chan
      sdi_drive_chan u_sdi_drive_chan (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_wr(chan_wr[g]),
        .i_wr_level(wr_level),
        .i_cal(i_cal[g]),
        .i_auto_amplitude_disable(o_auto_amplitude_disable),
        .o_level(lvl[g]),
        .o_cal(cal[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Read words
  // ==========================================================================
  // Calibrated field reads back as stored; reserved bits read zero
  assign word_drive2 = {lvl[0], cal[0], 6'h00};
  assign word_drive3 = {lvl[1], cal[1], 6'h00};

  // Control word, unused bits zero
  always_comb begin
    word_ctrl = 16'h0000;
    word_ctrl[sdi_pkg::SDI_CTRL_OVR_BIT] = o_drive_override_enable;
    word_ctrl[sdi_pkg::SDI_CTRL_AAD_BIT] = o_auto_amplitude_disable;
  end

  // Picks the addressed word; unmapped indices read zero
  always_comb begin
    word_sel = 16'h0000;
    case (idx)
      sdi_pkg::SDI_IDX_DRIVE_CHAN2: begin
        word_sel = word_drive2;
      end
      sdi_pkg::SDI_IDX_DRIVE_CHAN3: begin
        word_sel = word_drive3;
      end
      sdi_pkg::SDI_IDX_MAKER: begin
        word_sel = sdi_pkg::SDI_MAKER_CODE;
      end
      sdi_pkg::SDI_IDX_PART: begin
        word_sel = sdi_pkg::SDI_PART_CODE;
      end
      sdi_pkg::SDI_IDX_CTRL: begin
        word_sel = word_ctrl;
      end
      default: begin
        word_sel = 16'h0000;
      end
    endcase
  end

  // ==========================================================================
  // Bus answer
  // ==========================================================================
  // Ack one cycle after the take; data stands only in the ack cycle of a read
  always_comb begin
    next_ack = req;
    next_dat = 32'h0000_0000;
    if (rd) begin
      next_dat = {16'h0000, word_sel};
    end
  end

  // Registers for the bus answer
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_wb_dat <= 32'h0000_0000;
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_dat <= next_dat;
      o_wb_ack <= next_ack;
    end
  end

  // ==========================================================================
  // Control bits
  // ==========================================================================
  // Control bits change only on a lane 0 write to the control index
  always_comb begin
    next_ovr = o_drive_override_enable;
    next_aad = o_auto_amplitude_disable;
    if (wr_ctrl) begin
      next_ovr = wr_ovr;
      next_aad = wr_aad;
    end
  end

  // Registers for the control bits
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_drive_override_enable <= 1'b0;
      o_auto_amplitude_disable <= 1'b0;
    end else begin
      o_drive_override_enable <= next_ovr;
      o_auto_amplitude_disable <= next_aad;
    end
  end

  // ==========================================================================
  // Applied sensor drive
  // ==========================================================================
  // Programmed level under override, calibrated value otherwise
  // The new override value is used at once, so a control write shows a cycle early
  always_comb begin
    next_chan2 = cal[0];
    next_chan3 = cal[1];
    if (next_ovr) begin
      next_chan2 = lvl[0];
      next_chan3 = lvl[1];
    end
  end

  // Registers for the applied drive
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_chan2_drive_level <= sdi_pkg::SDI_LEVEL_RST;
      o_chan3_drive_level <= sdi_pkg::SDI_LEVEL_RST;
    end else begin
      o_chan2_drive_level <= next_chan2;
      o_chan3_drive_level <= next_chan3;
    end
  end

endmodule

// ===== sdi_regs_assertions.sv
`timescale 1ns/1ns
// ==========================================================================
// Register bank checker
module sdi_regs_assertions (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire sdi_pkg::sdi_wb_req_t i_wb,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire sdi_pkg::sdi_cal_t [1:0] i_cal,
  input wire logic [4:0] o_chan2_drive_level,
  input wire logic [4:0] o_chan3_drive_level,
  input wire logic o_drive_override_enable,
  input wire logic o_auto_amplitude_disable
);
  logic rq;
  logic wr;
  logic ov;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // Request taken, level-byte write, override state
  assign rq = i_wb.cyc && i_wb.stb && !o_wb_ack;
  assign wr = rq && i_wb.we && i_wb.sel[1];
  assign ov = o_drive_override_enable;
  lvl_two_a: assert property (wr && ov && i_wb.adr[9:2] == 8'h20
    |-> ##3 o_chan2_drive_level == $past(i_wb.dat[15:11], 3)) else $error("chan2 level");
  lvl_three_a: assert property (wr && ov && i_wb.adr[9:2] == 8'h21
    |-> ##3 o_chan3_drive_level == $past(i_wb.dat[15:11], 3)) else $error("chan3 level");
  cal_store_a: assert property (i_cal[0].valid && i_cal[0].initial_phase && !ov
    |-> ##3 o_chan2_drive_level == $past(i_cal[0].drive, 3)) else $error("cal store");
  cal_hold_a: assert property (i_cal[0].valid && !i_cal[0].initial_phase
    && o_auto_amplitude_disable && !ov |=> $stable(o_chan2_drive_level)[*3])
    else $error("cal hold");
  maker_code_a: assert property (rq && !i_wb.we && i_wb.adr[9:2] == 8'h7E
    |=> o_wb_dat[15:0] == sdi_pkg::SDI_MAKER_CODE) else $error("maker code");
  part_code_a: assert property (rq && !i_wb.we && i_wb.adr[9:2] == 8'h7F
    |=> o_wb_dat[15:0] == sdi_pkg::SDI_PART_CODE) else $error("part code");
  resv_zero_a: assert property (rq && !i_wb.we && i_wb.adr[9:3] == 7'h10
    |=> o_wb_dat[5:0] == 6'h00) else $error("reserved bits");
  ovr_write_a: assert property (rq && i_wb.we && i_wb.sel[0] && i_wb.adr[9:2] == 8'h40
    |=> o_drive_override_enable == $past(i_wb.dat[0])) else $error("override write");
  ack_answer_a: assert property (rq |=> o_wb_ack) else $error("no ack");
  ack_single_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
endmodule
bind sdi_regs sdi_regs_assertions u_sdi_regs_assertions (.i_ref_clk(i_ref_clk),
  .i_reset(i_reset), .i_wb(i_wb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_cal(i_cal),
  .o_chan2_drive_level(o_chan2_drive_level), .o_chan3_drive_level(o_chan3_drive_level),
  .o_drive_override_enable(o_drive_override_enable),
  .o_auto_amplitude_disable(o_auto_amplitude_disable));

// ===== sensor_drive_and_id_registers_tb.sv
`timescale 1ns/1ns
// ==========================================================================
// Register bank testbench
module sensor_drive_and_id_registers_tb;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  sdi_pkg::sdi_wb_req_t wb = '0;
  sdi_pkg::sdi_cal_t [1:0] cal = '0;
  logic [31:0] rdat;
  logic ack;
  logic [4:0] lvl2;
  logic [4:0] lvl3;
  logic [15:0] rd;
  logic [15:0] lv;
  logic ovr;
  logic aad;
  logic [3:0] lanes = 4'hF;
  int fails = 0;
  int num_checks = 0;
  int cyc_n = 0;
  sdi_regs u_sdi_regs (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_wb(wb), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_cal(cal), .o_chan2_drive_level(lvl2), .o_chan3_drive_level(lvl3),
    .o_drive_override_enable(ovr), .o_auto_amplitude_disable(aad));
  // Clock
  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // Hang guard
  always @(posedge i_ref_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 2000) begin
      fails = fails + 1;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One classic Wishbone cycle; answer taken and request released at the ack edge
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [15:0] d);
    @(posedge i_ref_clk);
    wb <= '{1'b1, 1'b1, we, lanes, {idx, 2'b00}, {16'h0000, d}};
    do @(posedge i_ref_clk); while (ack !== 1'b1);
    rd = rdat[15:0];
    lv = {6'h00, lvl3, lvl2};
    wb <= '0;
  endtask
  // One calibration result pulse
  task automatic pulse(input logic ch, input logic init, input logic [4:0] d);
    @(posedge i_ref_clk);
    cal[ch] <= '{1'b1, init, d};
    @(posedge i_ref_clk);
    cal[ch] <= '0;
    repeat (4) @(posedge i_ref_clk);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    xfer(1'b0, 8'h20, 16'h0000);
    check(rd, 16'h0000);
    xfer(1'b0, 8'h21, 16'h0000);
    check(rd, 16'h0000);
    xfer(1'b1, 8'h7E, 16'hFFFF);
    xfer(1'b0, 8'h7E, 16'h0000);
    check(rd, sdi_pkg::SDI_MAKER_CODE);
    xfer(1'b0, 8'h7F, 16'h0000);
    check(rd, sdi_pkg::SDI_PART_CODE);
    xfer(1'b0, 8'h30, 16'h0000);
    check(rd, 16'h0000);
    xfer(1'b1, 8'h40, 16'h0001);
    xfer(1'b0, 8'h40, 16'h0000);
    check(rd, 16'h0001);
    check({14'h0000, aad, ovr}, 16'h0001);
    xfer(1'b1, 8'h20, 16'hFFFF);
    xfer(1'b1, 8'h21, 16'h5AFF);
    xfer(1'b0, 8'h20, 16'h0000);
    check(rd, 16'hF800);
    xfer(1'b0, 8'h21, 16'h0000);
    check(rd, 16'h5800);
    check(lv, 16'h017F);
    lanes = 4'h1;
    xfer(1'b1, 8'h20, 16'h0000);
    lanes = 4'hF;
    xfer(1'b0, 8'h20, 16'h0000);
    check(rd, 16'hF800);
    xfer(1'b1, 8'h40, 16'h0002);
    xfer(1'b0, 8'h40, 16'h0000);
    check(rd, 16'h0002);
    check({14'h0000, aad, ovr}, 16'h0002);
    pulse(1'b0, 1'b1, 5'h15);
    xfer(1'b0, 8'h20, 16'h0000);
    check(rd, 16'hFD40);
    pulse(1'b0, 1'b0, 5'h0A);
    xfer(1'b0, 8'h20, 16'h0000);
    check(rd, 16'hFD40);
    xfer(1'b1, 8'h40, 16'h0000);
    pulse(1'b0, 1'b0, 5'h0A);
    pulse(1'b1, 1'b1, 5'h07);
    xfer(1'b0, 8'h20, 16'h0000);
    check(rd, 16'hFA80);
    xfer(1'b0, 8'h21, 16'h0000);
    check(rd, 16'h59C0);
    check(lv, 16'h00EA);
    wrap_up();
  end
endmodule
